// file: msfp_map.vh
// Summary of operation
// - after two minutes without a key, show the default message
// - a new trip or alarm replaces the current message at once
// - default is motor status when stopped, first user message when running
// - running lamp needs a closed relay confirmed by its status input
// - stopped lamp lights when both contactors are off
// - a trip that drops a relay sets tripped; starts refused while set
// - tripped clears by reset key, lockout switch or serial, per trip type
// - relay, aux, alarm and fault lamps follow their own sources
// - auto mode takes serial starts only
// - hardwired auto takes auto start inputs qualified by permissive only
// - stops are honoured in every mode from every source
// - manual takes switch and key starts; manual and auto lamps show mode
// - setpoint key steps through six pages, from actual values to page one
// - actual key steps through four pages, from setpoints to page one
// - value keys step the shown setpoint within limits, idle on actuals
// - start keys begin the start of their contactor, subject to gating
// - unstored edits leave the stored value in force
// - store in setpoint mode writes memory, applies, flashes stored message
// - store in actual mode selects the shown message as default
// - stop key drops both contactor relays
// - reset with trip cause present keeps trip and shows not-possible
// - section up/down bounded; holding beyond one second repeats fast
// - any trip drops both contactor relays
// - starts need the stop input energized; dropping it opens both relays
`ifndef MSFP_MAP_VH
`define MSFP_MAP_VH
`define MSFP_CLK_HZ      40'd50000000
`define MSFP_IDLE_S      40'd120
`define MSFP_HOLD_MS     40'd1000
`define MSFP_REP_MS      40'd100
`define MSFP_DEB_MS      40'd10
`define MSFP_MS_DIV      40'd1000
`define MSFP_K_SP        0
`define MSFP_K_ACT       1
`define MSFP_K_STORE     2
`define MSFP_K_STOP      3
`define MSFP_K_RESET     4
`define MSFP_K_STA       5
`define MSFP_K_STB       6
`define MSFP_K_UP        7
`define MSFP_K_DN        8
`define MSFP_K_VUP       9
`define MSFP_K_VDN       10
`define MSFP_S_STOP      11
`define MSFP_S_STA       12
`define MSFP_S_STB       13
`define MSFP_S_ASTA      14
`define MSFP_S_ASTB      15
`define MSFP_S_PERM      16
`define MSFP_S_LOCK      17
`define MSFP_S_STATA     18
`define MSFP_S_STATB     19
`define MSFP_MODE_MAN    2'h0
`define MSFP_MODE_AUTO   2'h1
`define MSFP_MODE_HW     2'h2
`define MSFP_TC_ANY      2'h0
`define MSFP_TC_LOCK     2'h1
`define MSFP_TC_SER      2'h2
`define MSFP_MSG_DATA    3'h0
`define MSFP_MSG_TRIP    3'h1
`define MSFP_MSG_ALARM   3'h2
`define MSFP_MSG_STATUS  3'h3
`define MSFP_MSG_USER1   3'h4
`define MSFP_MSG_STORED  3'h5
`define MSFP_MSG_NORST   3'h6
`define MSFP_SP_PAGES    3'h6
`define MSFP_AV_PAGES    3'h4
`define MSFP_SP_DEPTH    128
`endif

// file: msfp_panel.v
`timescale 1ns/1ns
`default_nettype none
`include "msfp_map.vh"

module msfp_panel #(
  parameter        SECT_N   = 8,
  parameter        SP_W     = 16,
  parameter [15:0] SP_MIN   = 16'h0000,
  parameter [15:0] SP_MAX   = 16'h00FF,
  parameter [15:0] SP_INIT  = 16'h0010,
  parameter [39:0] IDLE_CYC = `MSFP_CLK_HZ * `MSFP_IDLE_S,
  parameter [39:0] HOLD_CYC = `MSFP_CLK_HZ * `MSFP_HOLD_MS / `MSFP_MS_DIV,
  parameter [39:0] REP_CYC  = `MSFP_CLK_HZ * `MSFP_REP_MS / `MSFP_MS_DIV,
  parameter [39:0] DEB_CYC  = `MSFP_CLK_HZ * `MSFP_DEB_MS / `MSFP_MS_DIV
) (
  input  wire            ref_clk,
  input  wire            sys_rst,
  input  wire [10:0]     key_pins,
  input  wire [8:0]      sw_pins,
  input  wire [1:0]      ctl_mode,
  input  wire            ser_start_a,
  input  wire            ser_start_b,
  input  wire            ser_stop,
  input  wire            ser_reset,
  input  wire            trip_event,
  input  wire            trip_cond,
  input  wire [1:0]      trip_class,
  input  wire            alarm_active,
  input  wire            self_fault,
  input  wire            aux1_cmd,
  input  wire            aux2_cmd,
  output reg             relay_a_q,
  output reg             relay_b_q,
  output reg             aux1_relay_q,
  output reg             aux2_relay_q,
  output reg             lamp_running_q,
  output reg             lamp_stopped_q,
  output reg             lamp_tripped_q,
  output reg             lamp_alarm_q,
  output reg             lamp_fault_q,
  output reg             lamp_ctr_a_q,
  output reg             lamp_ctr_b_q,
  output reg             lamp_aux1_q,
  output reg             lamp_aux2_q,
  output reg             lamp_auto_q,
  output reg             lamp_manual_q,
  output reg [2:0]       disp_msg_q,
  output reg             disp_setpt_q,
  output reg [2:0]       disp_page_q,
  output reg [3:0]       disp_sect_q,
  output reg [SP_W-1:0]  sp_shown_q,
  output reg [SP_W-1:0]  sp_active_q,
  output reg             nv_wr_q,
  output reg [6:0]       nv_addr_q,
  output reg [SP_W-1:0]  nv_data_q,
  output reg             default_sel_q,
  output reg [6:0]       default_addr_q
);

  localparam IN_N = 20;
  localparam [3:0] SECT_LAST = SECT_N - 1;

  ////////////////////////////////////////////////////////////////////
  // input synchronising and debouncing
  wire [IN_N-1:0] pins = {sw_pins, key_pins};
  reg  [IN_N-1:0] s1_q;
  reg  [IN_N-1:0] s2_q;
  reg  [IN_N-1:0] s3_q;
  wire [IN_N-1:0] filt_q;
  reg  [IN_N-1:0] filt_old_q;
  wire [IN_N-1:0] ev = filt_q & ~filt_old_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q       <= {IN_N{1'b0}};
      s2_q       <= {IN_N{1'b0}};
      s3_q       <= {IN_N{1'b0}};
      filt_old_q <= {IN_N{1'b0}};
    end else begin
      s1_q       <= pins;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      filt_old_q <= filt_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IN_N; gi = gi + 1) begin : g_deb
      reg [39:0] cnt_q;
      reg        lvl_q;
      // one flop per bit keeps a single driver for each filtered level
      assign filt_q[gi] = lvl_q;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          cnt_q <= 40'h0;
          lvl_q <= 1'b0;
        end else if (s2_q[gi] != s3_q[gi] || s3_q[gi] == lvl_q) begin
          cnt_q <= 40'h0;
        end else if (cnt_q >= DEB_CYC - 40'h1) begin
          cnt_q <= 40'h0;
          lvl_q <= s3_q[gi];
        end else begin
          cnt_q <= cnt_q + 40'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // hold to repeat for section keys
  reg  [39:0] hold_q;
  reg  [39:0] rep_q;
  reg         rep_tick_q;
  wire        nav_held = filt_q[`MSFP_K_UP] | filt_q[`MSFP_K_DN];

  always @(posedge ref_clk) begin
    if (sys_rst || !nav_held) begin
      hold_q     <= 40'h0;
      rep_q      <= 40'h0;
      rep_tick_q <= 1'b0;
    end else if (hold_q < HOLD_CYC) begin
      hold_q     <= hold_q + 40'h1;
      rep_tick_q <= 1'b0;
    end else if (rep_q >= REP_CYC - 40'h1) begin
      rep_q      <= 40'h0;
      rep_tick_q <= 1'b1;
    end else begin
      rep_q      <= rep_q + 40'h1;
      rep_tick_q <= 1'b0;
    end
  end

  wire go_up = ev[`MSFP_K_UP] | (rep_tick_q & filt_q[`MSFP_K_UP]);
  wire go_dn = ev[`MSFP_K_DN] | (rep_tick_q & filt_q[`MSFP_K_DN]);
  wire any_key = |ev[`MSFP_K_VDN:`MSFP_K_SP] | rep_tick_q;

  ////////////////////////////////////////////////////////////////////
  // start and stop gating, trip latch
  wire stop_ok = filt_q[`MSFP_S_STOP];
  wire stop_any = ev[`MSFP_K_STOP] | ser_stop | ~stop_ok;
  wire man = (ctl_mode == `MSFP_MODE_MAN);
  wire aut = (ctl_mode == `MSFP_MODE_AUTO);
  wire hwa = (ctl_mode == `MSFP_MODE_HW);
  wire perm = filt_q[`MSFP_S_PERM];
  wire req_a = (man & (ev[`MSFP_K_STA] | filt_q[`MSFP_S_STA]))
             | (aut & ser_start_a)
             | (hwa & perm & filt_q[`MSFP_S_ASTA]);
  wire req_b = (man & (ev[`MSFP_K_STB] | filt_q[`MSFP_S_STB]))
             | (aut & ser_start_b)
             | (hwa & perm & filt_q[`MSFP_S_ASTB]);
  wire start_ok = stop_ok & ~lamp_tripped_q;

  reg [1:0] tclass_q;
  wire key_rst = ev[`MSFP_K_RESET];
  wire lock_rst = ev[`MSFP_S_LOCK];
  wire rst_req = (tclass_q == `MSFP_TC_ANY) ? (key_rst | lock_rst | ser_reset) :
                 (tclass_q == `MSFP_TC_LOCK) ? lock_rst : ser_reset;
  wire rst_go = lamp_tripped_q & rst_req & ~trip_cond;
  wire rst_deny = lamp_tripped_q & (key_rst | lock_rst | ser_reset) & trip_cond;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      relay_a_q      <= 1'b0;
      relay_b_q      <= 1'b0;
      lamp_tripped_q <= 1'b0;
      tclass_q       <= `MSFP_TC_ANY;
    end else begin
      if (trip_event || stop_any) begin
        relay_a_q <= 1'b0;
        relay_b_q <= 1'b0;
      end else if (start_ok) begin
        if (req_a)
          relay_a_q <= 1'b1;
        if (req_b)
          relay_b_q <= 1'b1;
      end
      if (trip_event) begin
        lamp_tripped_q <= 1'b1;
        tclass_q       <= trip_class;
      end else if (rst_go) begin
        lamp_tripped_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // lamps
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      lamp_running_q <= 1'b0;
      lamp_stopped_q <= 1'b0;
      lamp_alarm_q   <= 1'b0;
      lamp_fault_q   <= 1'b0;
      lamp_ctr_a_q   <= 1'b0;
      lamp_ctr_b_q   <= 1'b0;
      lamp_aux1_q    <= 1'b0;
      lamp_aux2_q    <= 1'b0;
      lamp_auto_q    <= 1'b0;
      lamp_manual_q  <= 1'b0;
      aux1_relay_q   <= 1'b0;
      aux2_relay_q   <= 1'b0;
    end else begin
      lamp_running_q <= (relay_a_q & filt_q[`MSFP_S_STATA])
                      | (relay_b_q & filt_q[`MSFP_S_STATB]);
      lamp_stopped_q <= ~filt_q[`MSFP_S_STATA] & ~filt_q[`MSFP_S_STATB];
      aux1_relay_q   <= aux1_cmd;
      aux2_relay_q   <= aux2_cmd;
      lamp_ctr_a_q   <= relay_a_q;
      lamp_ctr_b_q   <= relay_b_q;
      lamp_aux1_q    <= aux1_relay_q;
      lamp_aux2_q    <= aux2_relay_q;
      lamp_alarm_q   <= alarm_active;
      lamp_fault_q   <= self_fault;
      lamp_auto_q    <= aut | hwa;
      lamp_manual_q  <= man;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // page navigation and setpoint editing
  // one entry per {page,sect} code so every page stays addressable
  reg  [SP_W-1:0] sp_mem [0:`MSFP_SP_DEPTH-1];
  reg             dirty_q;
  reg             alarm_old_q;
  reg  [39:0]     idle_q;
  wire [6:0]      addr = {disp_page_q, disp_sect_q[3:0]};
  wire            sp_mode = disp_setpt_q;
  integer         i;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      for (i = 0; i < `MSFP_SP_DEPTH; i = i + 1)
        sp_mem[i] <= SP_INIT;
      disp_setpt_q   <= 1'b0;
      disp_page_q    <= 3'h0;
      disp_sect_q    <= 4'h0;
      disp_msg_q     <= `MSFP_MSG_STATUS;
      sp_shown_q     <= SP_INIT;
      sp_active_q    <= SP_INIT;
      dirty_q        <= 1'b0;
      nv_wr_q        <= 1'b0;
      nv_addr_q      <= 7'h00;
      nv_data_q      <= {SP_W{1'b0}};
      default_sel_q  <= 1'b0;
      default_addr_q <= 7'h00;
      alarm_old_q    <= 1'b0;
      idle_q         <= 40'h0;
    end else begin
      nv_wr_q       <= 1'b0;
      default_sel_q <= 1'b0;
      alarm_old_q   <= alarm_active;
      sp_active_q   <= sp_mem[addr];
      if (!dirty_q)
        sp_shown_q <= sp_mem[addr];
      if (any_key) begin
        idle_q     <= 40'h0;
        disp_msg_q <= `MSFP_MSG_DATA;
      end else if (idle_q < IDLE_CYC) begin
        idle_q <= idle_q + 40'h1;
      end else begin
        disp_msg_q <= lamp_stopped_q ? `MSFP_MSG_STATUS : `MSFP_MSG_USER1;
      end
      if (ev[`MSFP_K_SP]) begin
        dirty_q      <= 1'b0;
        disp_setpt_q <= 1'b1;
        disp_sect_q  <= 4'h0;
        if (!sp_mode || disp_page_q == `MSFP_SP_PAGES - 3'h1)
          disp_page_q <= 3'h0;
        else
          disp_page_q <= disp_page_q + 3'h1;
      end else if (ev[`MSFP_K_ACT]) begin
        dirty_q      <= 1'b0;
        disp_setpt_q <= 1'b0;
        disp_sect_q  <= 4'h0;
        if (sp_mode || disp_page_q == `MSFP_AV_PAGES - 3'h1)
          disp_page_q <= 3'h0;
        else
          disp_page_q <= disp_page_q + 3'h1;
      end else if (go_up && disp_sect_q != 4'h0) begin
        dirty_q     <= 1'b0;
        disp_sect_q <= disp_sect_q - 4'h1;
      end else if (go_dn && disp_sect_q != SECT_LAST) begin
        dirty_q     <= 1'b0;
        disp_sect_q <= disp_sect_q + 4'h1;
      end else if (sp_mode && ev[`MSFP_K_VUP]) begin
        dirty_q <= 1'b1;
        if (sp_shown_q < SP_MAX)
          sp_shown_q <= sp_shown_q + 1'b1;
      end else if (sp_mode && ev[`MSFP_K_VDN]) begin
        dirty_q <= 1'b1;
        if (sp_shown_q > SP_MIN)
          sp_shown_q <= sp_shown_q - 1'b1;
      end else if (ev[`MSFP_K_STORE]) begin
        if (sp_mode) begin
          sp_mem[addr] <= sp_shown_q;
          dirty_q      <= 1'b0;
          nv_wr_q      <= 1'b1;
          nv_addr_q    <= addr;
          nv_data_q    <= sp_shown_q;
          disp_msg_q   <= `MSFP_MSG_STORED;
        end else begin
          default_sel_q  <= 1'b1;
          default_addr_q <= addr;
        end
      end
      if (rst_deny)
        disp_msg_q <= `MSFP_MSG_NORST;
      if (alarm_active && !alarm_old_q)
        disp_msg_q <= `MSFP_MSG_ALARM;
      if (trip_event)
        disp_msg_q <= `MSFP_MSG_TRIP;
    end
  end

endmodule // msfp_panel
`default_nettype wire

// file: msfp_panel_end.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: msfp_panel_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "msfp_map.vh"
module msfp_panel_chk #(
  parameter SP_W = 16
) (
  input wire logic            ref_clk,
  input wire logic            sys_rst,
  input wire logic [1:0]      ctl_mode,
  input wire logic            ser_start_a,
  input wire logic            ser_stop,
  input wire logic            trip_event,
  input wire logic            aux1_cmd,
  input wire logic            relay_a_q,
  input wire logic            relay_b_q,
  input wire logic            lamp_tripped_q,
  input wire logic            lamp_ctr_a_q,
  input wire logic            lamp_aux1_q,
  input wire logic            lamp_auto_q,
  input wire logic            lamp_manual_q,
  input wire logic [2:0]      disp_msg_q,
  input wire logic [SP_W-1:0] sp_active_q,
  input wire logic            nv_wr_q,
  input wire logic [SP_W-1:0] nv_data_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_trip_opens: assert property (trip_event |=> !relay_a_q && !relay_b_q)
    else $error("relay closed after trip");
  a_trip_lamp: assert property (trip_event |=> lamp_tripped_q)
    else $error("tripped lamp not set");
  a_trip_msg: assert property (trip_event |=> disp_msg_q == `MSFP_MSG_TRIP)
    else $error("trip message not shown");
  a_ser_stop: assert property (ser_stop |=> !relay_a_q && !relay_b_q)
    else $error("serial stop ignored");
  a_auto_start: assert property ($rose(relay_a_q) && $past(ctl_mode) == `MSFP_MODE_AUTO
    |-> $past(ser_start_a))
    else $error("auto start without serial");
  a_start_trip: assert property ($rose(relay_a_q) |-> !$past(lamp_tripped_q))
    else $error("start while tripped");
  a_mode_lamps: assert property (ctl_mode == `MSFP_MODE_MAN [*4]
    |-> lamp_manual_q && !lamp_auto_q)
    else $error("mode lamps wrong");
  a_ctr_lamp: assert property ($stable(relay_a_q) [*3] |-> lamp_ctr_a_q == relay_a_q)
    else $error("contactor lamp wrong");
  a_aux_lamp: assert property ($stable(aux1_cmd) [*4] |-> lamp_aux1_q == aux1_cmd)
    else $error("aux lamp wrong");
  a_store_apply: assert property (nv_wr_q |=> sp_active_q == $past(nv_data_q))
    else $error("stored value not applied");
endmodule // msfp_panel_chk
bind msfp_panel msfp_panel_chk #(.SP_W(SP_W)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .ctl_mode(ctl_mode), .ser_start_a(ser_start_a),
  .ser_stop(ser_stop), .trip_event(trip_event), .aux1_cmd(aux1_cmd),
  .relay_a_q(relay_a_q), .relay_b_q(relay_b_q), .lamp_tripped_q(lamp_tripped_q),
  .lamp_ctr_a_q(lamp_ctr_a_q), .lamp_aux1_q(lamp_aux1_q), .lamp_auto_q(lamp_auto_q),
  .lamp_manual_q(lamp_manual_q), .disp_msg_q(disp_msg_q), .sp_active_q(sp_active_q),
  .nv_wr_q(nv_wr_q), .nv_data_q(nv_data_q)
);
`default_nettype wire

// file: msfp_operator.sv
`timescale 1ns/1ns
`default_nettype none
module msfp_operator (
  input  wire logic        ref_clk,
  input  wire logic        relay_a_q,
  input  wire logic        relay_b_q,
  output var  logic [10:0] key_pins,
  output var  logic [8:0]  sw_pins
);
  initial begin
    key_pins = 11'h000;
    sw_pins = 9'h000;
  end
  // contactor status contacts follow the relays
  always @(negedge ref_clk) begin
    sw_pins[7] <= relay_a_q;
    sw_pins[8] <= relay_b_q;
  end
  // short bounce first, then the real press
  task automatic press(input int k, input int hold);
    @(negedge ref_clk) key_pins[k] = 1'b1;
    @(negedge ref_clk) key_pins[k] = 1'b0;
    repeat (hold) @(negedge ref_clk) key_pins[k] = 1'b1;
    @(negedge ref_clk) key_pins[k] = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule // msfp_operator
`default_nettype wire

// file: msfp_panel_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "msfp_map.vh"
module msfp_panel_test;
  logic        ref_clk, sys_rst, ser_start_a, ser_start_b, ser_stop, ser_reset, ok;
  logic        trip_event, trip_cond, alarm_active, self_fault, aux1_cmd, aux2_cmd;
  logic [1:0]  ctl_mode, trip_class;
  logic [19:0] note;
  logic [19:0] q[$];
  logic [31:0] rnd;
  int          err_count, n_checks, n;
  wire  [10:0] key_pins;
  wire  [8:0]  sw_pins;
  wire         relay_a_q, relay_b_q, lamp_running_q, lamp_stopped_q, lamp_tripped_q;
  wire         lamp_auto_q, lamp_manual_q, disp_setpt_q;
  wire         lamp_alarm_q, lamp_fault_q, lamp_ctr_a_q, lamp_ctr_b_q;
  wire         lamp_aux1_q, lamp_aux2_q, aux1_relay_q, aux2_relay_q;
  wire  [6:0]  default_addr_q, nv_addr_q;
  wire  [15:0] nv_data_q;
  wire  [2:0]  disp_msg_q, disp_page_q;
  wire  [3:0]  disp_sect_q;
  wire  [15:0] sp_shown_q, sp_active_q;
  msfp_operator op (.ref_clk(ref_clk), .relay_a_q(relay_a_q), .relay_b_q(relay_b_q),
    .key_pins(key_pins), .sw_pins(sw_pins));
  msfp_panel #(.DEB_CYC(40'h3), .HOLD_CYC(40'h14), .REP_CYC(40'h4), .IDLE_CYC(40'hC8),
    .SP_INIT(16'h0002)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .key_pins(key_pins), .sw_pins(sw_pins),
    .ctl_mode(ctl_mode), .ser_start_a(ser_start_a), .ser_start_b(ser_start_b),
    .ser_stop(ser_stop), .ser_reset(ser_reset), .trip_event(trip_event),
    .trip_cond(trip_cond), .trip_class(trip_class), .alarm_active(alarm_active),
    .self_fault(self_fault), .aux1_cmd(aux1_cmd), .aux2_cmd(aux2_cmd),
    .relay_a_q(relay_a_q), .relay_b_q(relay_b_q), .aux1_relay_q(aux1_relay_q),
    .aux2_relay_q(aux2_relay_q),
    .lamp_running_q(lamp_running_q), .lamp_stopped_q(lamp_stopped_q),
    .lamp_tripped_q(lamp_tripped_q), .lamp_alarm_q(lamp_alarm_q),
    .lamp_fault_q(lamp_fault_q), .lamp_ctr_a_q(lamp_ctr_a_q), .lamp_ctr_b_q(lamp_ctr_b_q),
    .lamp_aux1_q(lamp_aux1_q), .lamp_aux2_q(lamp_aux2_q), .lamp_auto_q(lamp_auto_q),
    .lamp_manual_q(lamp_manual_q), .disp_msg_q(disp_msg_q), .disp_setpt_q(disp_setpt_q),
    .disp_page_q(disp_page_q), .disp_sect_q(disp_sect_q), .sp_shown_q(sp_shown_q),
    .sp_active_q(sp_active_q), .nv_wr_q(), .nv_addr_q(nv_addr_q), .nv_data_q(nv_data_q),
    .default_sel_q(), .default_addr_q(default_addr_q));
  ////////////////////////////////////////
  function automatic [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [15:0] obs(input [3:0] s);
    case (s)
      0: obs = {14'h0, relay_b_q, relay_a_q};
      1: obs = {15'h0, lamp_tripped_q};
      2: obs = {13'h0, disp_msg_q};
      3: obs = {8'h0, disp_setpt_q, disp_page_q, disp_sect_q};
      4: obs = sp_shown_q;
      5: obs = sp_active_q;
      7: obs = {8'h0, aux1_relay_q, aux2_relay_q, lamp_alarm_q, lamp_fault_q, lamp_aux1_q,
                lamp_aux2_q, lamp_ctr_a_q, lamp_ctr_b_q};
      8: obs = {2'h0, default_addr_q, nv_addr_q};
      9: obs = nv_data_q;
      default: obs = {12'h0, lamp_running_q, lamp_stopped_q, lamp_auto_q, lamp_manual_q};
    endcase
  endfunction
  task automatic check(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic want(input [3:0] s, input [15:0] v);
    q.push_back({s, v});
  endtask
  // notes are compared on settled pre-edge values
  always @(posedge ref_clk) begin
    while (q.size() != 0) begin
      note = q.pop_front();
      check(obs(note[19:16]), note[15:0]);
    end
  end
  task automatic ser(input int k);
    @(negedge ref_clk);
    case (k)
      0: ser_start_a = 1'b1;
      1: ser_stop = 1'b1;
      2: ser_reset = 1'b1;
      default: trip_event = 1'b1;
    endcase
    @(negedge ref_clk);
    {ser_start_a, ser_stop, ser_reset, trip_event} = 4'h0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic sw_pulse(input int b, input logic v);
    op.sw_pins[b] = v;
    repeat (12) @(negedge ref_clk);
    op.sw_pins[b] = !v;
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic clr(input int s);
    case (s)
      0: op.press(`MSFP_K_RESET, 6);
      1: sw_pulse(6, 1'b1);
      default: ser(2);
    endcase
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    {ser_start_a, ser_start_b, ser_stop, ser_reset, trip_event, trip_cond} = 6'h00;
    {alarm_active, self_fault, aux1_cmd, aux2_cmd, ctl_mode, trip_class} = 8'h00;
    err_count = 0;
    n_checks = 0;
    rnd = 32'h8BB8;
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    op.sw_pins[0] = 1'b1;
    repeat (12) @(negedge ref_clk);
    want(6, 16'h0005);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 3; s++) begin
        rnd = lfsr_next(rnd);
        {alarm_active, self_fault, aux1_cmd, aux2_cmd} = rnd[3:0];
        ctl_mode = 2'(m);
        repeat (4) @(negedge ref_clk);
        ok = (s == (m == 0 ? 1 : m == 1 ? 0 : 2));
        case (s)
          0: ser(0);
          1: op.press(`MSFP_K_STA, 6);
          default: sw_pulse(3, 1'b1) ;
        endcase
        want(0, {15'h0, ok});
        repeat (12) @(negedge ref_clk);
        want(6, {12'h0, ok, !ok, m != 0, m == 0});
        want(7, {8'h0, rnd[1:0], rnd[3:0], ok, 1'b0});
        case (m)
          0: op.press(`MSFP_K_STOP, 6);
          1: ser(1);
          default: sw_pulse(0, 1'b0);
        endcase
        want(0, 16'h0000);
        repeat (12) @(negedge ref_clk);
      end
      if (m == 1) op.sw_pins[5] = 1'b1;
    end
    $display("test modes done");
    {ctl_mode, alarm_active} = 3'h0;
    op.sw_pins[0] = 1'b0;
    repeat (12) @(negedge ref_clk);
    op.press(`MSFP_K_STA, 6);
    want(0, 16'h0000);
    op.sw_pins[0] = 1'b1;
    repeat (12) @(negedge ref_clk);
    sw_pulse(1, 1'b1);
    op.press(`MSFP_K_STB, 6);
    want(0, 16'h0003);
    op.press(`MSFP_K_STOP, 6);
    want(0, 16'h0000);
    repeat (12) @(negedge ref_clk);
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 3; s++) begin
        op.press(`MSFP_K_STA, 6);
        trip_class = 2'(c);
        trip_cond = 1'b1;
        ser(3);
        want(0, 16'h0000);
        want(2, {13'h0, `MSFP_MSG_TRIP});
        clr(s);
        want(2, {13'h0, `MSFP_MSG_NORST});
        op.press(`MSFP_K_STA, 6);
        want(0, 16'h0000);
        trip_cond = 1'b0;
        clr(s);
        want(1, {15'h0, !(c == 0 || c == s)});
        clr(c);
      end
    end
    $display("test trips done");
    op.press(`MSFP_K_SP, 6);
    want(3, 16'h0080);
    for (int i = 1; i < 7; i++) begin
      op.press(`MSFP_K_SP, 6);
      want(3, {8'h0, 1'b1, 3'(i % 6), 4'h0});
    end
    for (int i = 0; i < 5; i++) begin
      op.press(`MSFP_K_ACT, 6);
      want(3, {9'h0, 3'(i % 4), 4'h0});
    end
    op.press(`MSFP_K_UP, 6);
    want(3, 16'h0000);
    op.press(`MSFP_K_DN, 6);
    want(3, 16'h0001);
    op.press(`MSFP_K_DN, 60);
    want(3, 16'h0007);
    op.press(`MSFP_K_STORE, 6);
    want(8, 16'h0380);
    want(2, {13'h0, `MSFP_MSG_DATA});
    $display("test navigation done");
    op.press(`MSFP_K_SP, 6);
    repeat (3) op.press(`MSFP_K_VDN, 6);
    want(4, 16'h0000);
    n = int'(rnd[5:4]) + 1;
    repeat (n) op.press(`MSFP_K_VUP, 6);
    want(4, 16'(n));
    want(5, 16'h0002);
    op.press(`MSFP_K_STORE, 6);
    want(5, 16'(n));
    want(2, {13'h0, `MSFP_MSG_STORED});
    want(8, 16'h0380);
    want(9, 16'(n));
    $display("test setpoints done");
    alarm_active = 1'b1;
    repeat (2) @(negedge ref_clk);
    want(2, {13'h0, `MSFP_MSG_ALARM});
    alarm_active = 1'b0;
    repeat (260) @(negedge ref_clk);
    want(2, {13'h0, `MSFP_MSG_STATUS});
    op.press(`MSFP_K_STA, 6);
    repeat (260) @(negedge ref_clk);
    want(2, {13'h0, `MSFP_MSG_USER1});
    $display("test idle done");
    repeat (2) @(negedge ref_clk);
    summarize;
  end
endmodule // msfp_panel_test
`default_nettype wire
